// ===== rtl/gbm_params.svh
// Offsets, reset values and timing constants of the gate button menu.
`ifndef GBM_PARAMS_SVH
`define GBM_PARAMS_SVH
`define GBM_CLK_HZ 25000000
`define GBM_HOLD_ENTER_S 5
`define GBM_IDLE_EXIT_S 10
`define GBM_PAUSE_DEFAULT_S 30
`define GBM_PAUSE_PHOTO_S 5
`define GBM_ENTER_CYC (`GBM_HOLD_ENTER_S * `GBM_CLK_HZ)
`define GBM_IDLE_CYC (`GBM_IDLE_EXIT_S * `GBM_CLK_HZ)
`define GBM_SEC_CYC `GBM_CLK_HZ
`define GBM_BLINK_CYC 2500000
`define GBM_OFF_CTRL 32'h00000000
`define GBM_OFF_FUNC 32'h00000004
`define GBM_OFF_PAUSE 32'h00000008
`define GBM_OFF_STATUS 32'h0000000c
`define GBM_FUNC_RESET 8'h00
`define GBM_PAUSE_RESET 8'h1e
`define GBM_BIT_AUTO 0
`define GBM_BIT_PHOTO 1
`endif

// ===== rtl/gbm_pkg.sv
// Types shared by the gate button menu files.
package gbm_pkg;
  typedef enum logic [1:0] {
    GBM_IDLE,
    GBM_OPENING,
    GBM_CLOSING,
    GBM_PAUSE
  } gbm_motion_t;
  typedef enum logic [1:0] {
    GBM_NORMAL,
    GBM_ENTER_WAIT,
    GBM_PROGRAM
  } gbm_menu_t;
endpackage

// ===== rtl/gbm_press.sv
// Press edge and hold timer for one button.
`timescale 1ns/1ns
module gbm_press #(
  parameter int HOLD_CYC = 125000000
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Button level and derived events.
  input wire logic btn,
  output logic press,
  output logic held
);
  localparam int W = $clog2(HOLD_CYC + 1);
  initial begin
    if (HOLD_CYC < 1) $error("HOLD_CYC must be positive");
  end
  logic prev_q;
  logic [W-1:0] cnt_q;
  wire at_end = (cnt_q == W'(HOLD_CYC));
  assign press = btn & ~prev_q;
  assign held = btn & (cnt_q == W'(HOLD_CYC - 1));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      prev_q <= btn;
      cnt_q <= !btn ? '0 : (at_end ? cnt_q : cnt_q + W'(1));
    end
  end
endmodule

// ===== rtl/gbm_blink.sv
// Flash pattern generator for cursor and safety acknowledge.
`timescale 1ns/1ns
module gbm_blink #(
  parameter int STEP_CYC = 2500000
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Pattern ticks.
  output logic tick,
  output logic [3:0] phase
);
  localparam int W = $clog2(STEP_CYC + 1);
  initial begin
    if (STEP_CYC < 2) $error("STEP_CYC must be at least 2");
  end
  logic [W-1:0] cnt_q;
  logic [3:0] ph_q;
  assign tick = (cnt_q == W'(STEP_CYC - 1));
  assign phase = ph_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      ph_q <= 4'h0;
    end else begin
      cnt_q <= tick ? '0 : cnt_q + W'(1);
      if (tick) ph_q <= ph_q + 4'h1;
    end
  end
endmodule

// ===== rtl/gbm_top.sv
// Gate button menu, on/off function store and automatic closing pause logic.
//
// What this block does
// - Open button commands opening from rest outside programming and only moves the cursor inside it.
// - Close button commands closing from rest outside programming, moves the cursor inside it, and cancels any running pause.
// - A halt/select press during a running manoeuvre stops it.
// - Holding halt/select for more than 5 seconds enters programming mode.
// - On entering programming the first LED flashes as the auto close cursor.
// - In programming each open or close press moves the cursor among the eight LEDs.
// - A halt/select press toggles the selected function, short flash off, long flash on.
// - Ten seconds without a press leaves programming and keeps all changes.
// - All functions reset disabled and stay changeable at any time.
// - Outside programming each LED is lit when its function is enabled.
// - Each safety intervention gives two quick flashes on the bus status LED.
// - With auto close on, the set pause after opening leads to an automatic close, default 30 s.
// - Photo reclose and auto close on: a photocell hit in motion cuts the pause to 5 s.
// - Photo reclose on, auto close off: a photocell hit while closing recloses after the pause.
// - Photo reclose off uses the programmed pause, and no reclose without auto close.
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "gbm_params.svh"
module gbm_top import gbm_pkg::*; #(
  parameter int ENTER_CYC = `GBM_ENTER_CYC,
  parameter int IDLE_CYC = `GBM_IDLE_CYC,
  parameter int SEC_CYC = `GBM_SEC_CYC,
  parameter int BLINK_CYC = `GBM_BLINK_CYC
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Operator buttons, high while pressed.
  input wire logic btn_open,
  input wire logic btn_halt,
  input wire logic btn_close,
  // Photocell and safety inputs, high while interrupted.
  input wire logic photo,
  input wire logic safety_event,
  // Sequencer handshake.
  input wire logic open_done,
  input wire logic close_done,
  output logic cmd_open,
  output logic cmd_close,
  output logic cmd_stop,
  // Indicators.
  output logic [7:0] function_led_row,
  output logic bus_led,
  output logic prog_active,
  // AXI4-Lite slave.
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  initial begin
    if (ENTER_CYC < 2 || IDLE_CYC < 2 || SEC_CYC < 1 || BLINK_CYC < 2)
      $error("gbm_top timing parameters too small");
  end
  localparam int IW = $clog2(IDLE_CYC + 1);
  localparam int SW = $clog2(SEC_CYC + 1);

  // Button events.
  logic open_press, halt_press, close_press, halt_held;
  gbm_press #(.HOLD_CYC(2)) u_open (.aclk(aclk), .aresetn(aresetn), .btn(btn_open),
    .press(open_press), .held());
  gbm_press #(.HOLD_CYC(ENTER_CYC)) u_halt (.aclk(aclk), .aresetn(aresetn), .btn(btn_halt),
    .press(halt_press), .held(halt_held));
  gbm_press #(.HOLD_CYC(2)) u_close (.aclk(aclk), .aresetn(aresetn), .btn(btn_close),
    .press(close_press), .held());
  logic blink_tick;
  logic [3:0] blink_phase;
  gbm_blink #(.STEP_CYC(BLINK_CYC)) u_blink (.aclk(aclk), .aresetn(aresetn),
    .tick(blink_tick), .phase(blink_phase));

  // State.
  gbm_menu_t menu_q, menu_d;
  gbm_motion_t mot_q, mot_d;
  logic [7:0] func_q, func_d;
  logic [7:0] pause_set_q;
  logic [2:0] cursor_q;
  logic [IW-1:0] idle_q;
  logic [SW-1:0] sec_q;
  logic [7:0] pause_left_q;
  logic photo_prev_q, photo_hit_q, photo_close_q;
  logic [2:0] ack_q;
  logic [3:0] ack_step_q;
  logic cmd_open_q, cmd_close_q, cmd_stop_q;
  logic [7:0] led_q;
  logic bus_led_q;
  logic prog_q;

  wire in_prog = (menu_q == GBM_PROGRAM);
  wire any_press = open_press | halt_press | close_press;
  wire idle_out = in_prog & (idle_q == IW'(IDLE_CYC - 1));
  wire moving = (mot_q == GBM_OPENING) | (mot_q == GBM_CLOSING);
  wire auto_on = func_q[`GBM_BIT_AUTO];
  wire photo_on = func_q[`GBM_BIT_PHOTO];
  wire photo_rise = photo & ~photo_prev_q;
  wire sec_tick = (sec_q == SW'(SEC_CYC - 1));
  wire pause_end = (mot_q == GBM_PAUSE) & sec_tick & (pause_left_q <= 8'h1);
  // Reclose when auto close is on, or when photo reclose caught a hit while closing.
  wire reclose = auto_on | (photo_on & photo_close_q);
  wire [7:0] pause_len = (photo_on & auto_on & photo_hit_q) ? 8'(`GBM_PAUSE_PHOTO_S)
                                                            : pause_set_q;

  // Bus writes.
  logic aw_q, w_q;
  logic [31:0] awaddr_q, wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q, arready_q, rvalid_q;
  logic awready_q, wready_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  wire wr_fire = aw_q & w_q & ~bvalid_q;
  wire wr_func = wr_fire & (awaddr_q[7:0] == 8'(`GBM_OFF_FUNC)) & wstrb_q[0];
  wire wr_pause = wr_fire & (awaddr_q[7:0] == 8'(`GBM_OFF_PAUSE)) & wstrb_q[0];
  wire wr_ctrl = wr_fire & (awaddr_q[7:0] == 8'(`GBM_OFF_CTRL)) & wstrb_q[0];
  wire wr_hit = (awaddr_q[7:0] <= 8'(`GBM_OFF_STATUS)) & (awaddr_q[1:0] == 2'b00) &
                (awaddr_q[31:8] == 24'h0);
  wire toggle = in_prog & halt_press;
  wire [7:0] toggled = func_q ^ (8'h01 << cursor_q);

  // Menu next state.
  always_comb begin
    menu_d = menu_q;
    case (menu_q)
      GBM_NORMAL: if (halt_held) menu_d = GBM_ENTER_WAIT;
      GBM_ENTER_WAIT: if (!btn_halt) menu_d = GBM_PROGRAM;
      GBM_PROGRAM: if (idle_out) menu_d = GBM_NORMAL;
      default: menu_d = GBM_NORMAL;
    endcase
  end

  // Function settings: changeable from menu or bus at any time.
  always_comb begin
    func_d = func_q;
    if (toggle) func_d = toggled;
    else if (wr_func) func_d = wdata_q[7:0];
  end

  // Manoeuvre tracking.
  always_comb begin
    mot_d = mot_q;
    case (mot_q)
      GBM_IDLE: begin
        if (!in_prog && menu_q == GBM_NORMAL && open_press) mot_d = GBM_OPENING;
        else if (!in_prog && menu_q == GBM_NORMAL && close_press) mot_d = GBM_CLOSING;
      end
      GBM_OPENING: begin
        if (halt_press) mot_d = GBM_IDLE;
        else if (open_done) mot_d = reclose ? GBM_PAUSE : GBM_IDLE;
      end
      GBM_CLOSING: begin
        if (halt_press) mot_d = GBM_IDLE;
        // A finished close pauses again only after a photocell hit, else auto close would loop.
        else if (close_done) mot_d = (photo_on & photo_close_q) ? GBM_PAUSE : GBM_IDLE;
      end
      GBM_PAUSE: begin
        if (halt_press || close_press) mot_d = GBM_IDLE;
        else if (pause_end) mot_d = GBM_CLOSING;
      end
      default: mot_d = GBM_IDLE;
    endcase
  end

  wire start_pause = (mot_q != GBM_PAUSE) & (mot_d == GBM_PAUSE);

  // Retained-style settings storage and menu counters.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      menu_q <= GBM_NORMAL;
      func_q <= `GBM_FUNC_RESET;
      pause_set_q <= `GBM_PAUSE_RESET;
      cursor_q <= 3'h0;
      idle_q <= '0;
      prog_q <= 1'b0;
    end else begin
      menu_q <= menu_d;
      // Registered from the next menu state so the pin tracks the menu with no gate after it.
      prog_q <= (menu_d == GBM_PROGRAM);
      func_q <= func_d;
      if (wr_pause) pause_set_q <= (wdata_q[7:0] == 8'h0) ? 8'h1 : wdata_q[7:0];
      if (menu_q == GBM_ENTER_WAIT) cursor_q <= 3'h0;
      else if (in_prog && open_press) cursor_q <= cursor_q + 3'h1;
      else if (in_prog && close_press) cursor_q <= cursor_q - 3'h1;
      idle_q <= (!in_prog || any_press) ? '0 : idle_q + IW'(1);
    end
  end

  // Pause timer and photocell tracking.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mot_q <= GBM_IDLE;
      sec_q <= '0;
      pause_left_q <= 8'h0;
      photo_prev_q <= 1'b0;
      photo_hit_q <= 1'b0;
      photo_close_q <= 1'b0;
    end else begin
      mot_q <= mot_d;
      photo_prev_q <= photo;
      sec_q <= (start_pause || sec_tick) ? '0 : sec_q + SW'(1);
      if (start_pause) pause_left_q <= pause_len;
      else if (mot_q == GBM_PAUSE && sec_tick) pause_left_q <= pause_left_q - 8'h1;
      if (moving && photo_rise) photo_hit_q <= 1'b1;
      else if (start_pause || mot_q == GBM_IDLE) photo_hit_q <= 1'b0;
      if (mot_q == GBM_CLOSING && photo_rise) photo_close_q <= 1'b1;
      // Cleared when its pause starts, so one hit buys one reclose only.
      else if (mot_q == GBM_IDLE || mot_q == GBM_OPENING || start_pause) photo_close_q <= 1'b0;
    end
  end

  // Commands and indicators, all from flip-flops.
  wire run_open = (mot_q == GBM_IDLE) & (mot_d == GBM_OPENING);
  wire run_close = (mot_q != GBM_CLOSING) & (mot_d == GBM_CLOSING);
  wire run_stop = moving & halt_press;
  // Short flash is one step in eight, long flash seven in eight.
  wire cur_on = func_q[cursor_q] ? (blink_phase[2:0] != 3'h0) : (blink_phase[2:0] == 3'h0);
  logic [7:0] led_d;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_led
      assign led_d[gi] = (in_prog && cursor_q == 3'(gi)) ? cur_on : func_q[gi];
    end
  endgenerate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_open_q <= 1'b0;
      cmd_close_q <= 1'b0;
      cmd_stop_q <= 1'b0;
      led_q <= 8'h00;
      ack_q <= 3'h0;
      ack_step_q <= 4'h0;
      bus_led_q <= 1'b0;
    end else begin
      cmd_open_q <= run_open;
      cmd_close_q <= run_close;
      cmd_stop_q <= run_stop;
      led_q <= (menu_q == GBM_NORMAL) ? func_q : led_d;
      // Four blink steps give two quick flashes; a new event restarts the pattern.
      if (safety_event) begin
        ack_q <= 3'h4;
        ack_step_q <= 4'h0;
      end else if (ack_q != 3'h0 && blink_tick) begin
        ack_q <= ack_q - 3'h1;
      end
      bus_led_q <= (ack_q != 3'h0) ? ~ack_q[0] : blink_phase[3];
    end
  end
  assign cmd_open = cmd_open_q;
  assign cmd_close = cmd_close_q;
  assign cmd_stop = cmd_stop_q;
  assign function_led_row = led_q;
  assign bus_led = bus_led_q;
  assign prog_active = prog_q;

  // AXI4-Lite slave, one write and one read at a time.
  wire [7:0] ra = s_axi_araddr[7:0];
  wire rd_hit = (ra <= 8'(`GBM_OFF_STATUS)) & (ra[1:0] == 2'b00) & (s_axi_araddr[31:8] == 24'h0);
  wire [31:0] status_word = {24'h0, pause_left_q[3:0], 1'b0, 1'b0, mot_q};
  wire [31:0] rd_word = (ra == 8'(`GBM_OFF_FUNC)) ? {24'h0, func_q} :
                        (ra == 8'(`GBM_OFF_PAUSE)) ? {24'h0, pause_set_q} :
                        (ra == 8'(`GBM_OFF_STATUS)) ? status_word :
                        {30'h0, (menu_q == GBM_ENTER_WAIT), in_prog};
  // Read data is launched only after the address handshake, never alongside arready.
  wire ar_take = s_axi_arvalid & ~arready_q & ~rvalid_q;
  wire ar_hs = s_axi_arvalid & arready_q;
  // Ready flags come from the next write state so that every output leaves a flop.
  wire aw_take = s_axi_awvalid & awready_q;
  wire w_take = s_axi_wvalid & wready_q;
  wire aw_n = ~wr_fire & (aw_q | aw_take);
  wire w_n = ~wr_fire & (w_q | w_take);
  wire bv_n = wr_fire | (bvalid_q & ~s_axi_bready);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 32'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'b00;
      arready_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= 2'b00;
      rdata_q <= 32'h0;
    end else begin
      if (aw_take) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? 2'b00 : 2'b10;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      arready_q <= ar_take;
      awready_q <= ~aw_n & ~bv_n;
      wready_q <= ~w_n & ~bv_n;
      if (ar_hs) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_hit ? rd_word : 32'h0;
        rresp_q <= rd_hit ? 2'b00 : 2'b10;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end
  // The control word is write-ignored; mode is driven by the buttons only.
  wire unused_ok = wr_ctrl | ack_step_q[0];
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
endmodule

// ===== verification/gbm_top_assertions.sv
// Concurrent checks on the gate button menu ports.
`timescale 1ns/1ns
module gbm_top_checker #(
  parameter int ENTER_CYC = 20,
  parameter int IDLE_CYC = 50
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Buttons.
  input wire logic btn_open,
  input wire logic btn_halt,
  input wire logic btn_close,
  // Outputs watched.
  input wire logic cmd_open,
  input wire logic cmd_close,
  input wire logic cmd_stop,
  input wire logic [7:0] function_led_row,
  input wire logic prog_active
);
  logic [2:0] btn_q;
  logic [31:0] idle_q;
  logic [31:0] hold_q;
  wire logic [2:0] btn_now = {btn_close, btn_halt, btn_open};
  wire logic any_press = |(btn_now & ~btn_q);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Counters keep the long timing checks free of big repetitions.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      btn_q <= 3'h0;
      idle_q <= 32'h0;
      hold_q <= 32'h0;
    end else begin
      btn_q <= btn_now;
      idle_q <= (!prog_active || any_press) ? 32'h0 : idle_q + 32'h1;
      hold_q <= !btn_halt ? hold_q : (btn_q[1] ? hold_q + 32'h1 : 32'h1);
    end
  end
  AST_OPEN_PULSE: assert property (cmd_open |=> !cmd_open)
    else $error("open command longer than one cycle");
  AST_OPEN_CAUSE: assert property (cmd_open |-> $past(btn_open) || $past(btn_open, 2))
    else $error("open command without open button");
  AST_NO_OPEN_IN_PROG: assert property (prog_active && $past(prog_active) |-> !cmd_open)
    else $error("open command while programming");
  AST_STOP_CAUSE: assert property (cmd_stop |-> $past(btn_halt) || $past(btn_halt, 2))
    else $error("stop command without halt button");
  AST_ENTER_HOLD: assert property ($rose(prog_active) |-> hold_q >= ENTER_CYC - 1)
    else $error("programming entered after a short hold");
  AST_IDLE_LATE: assert property (prog_active |-> idle_q <= IDLE_CYC + 4)
    else $error("programming not left after idle time");
  AST_IDLE_EARLY: assert property ($fell(prog_active) |-> idle_q >= IDLE_CYC - 4)
    else $error("programming left too early");
  AST_FACTORY_OFF: assert property ($rose(aresetn) |-> function_led_row == 8'h00)
    else $error("functions not disabled after reset");
  AST_ONE_CMD: assert property ($onehot0({cmd_open, cmd_close, cmd_stop}))
    else $error("two motion commands at once");
endmodule

// ===== verification/gbm_seq_model.sv
// Sequencer and photocell model facing the gate button menu.
`timescale 1ns/1ns
module gbm_seq_model (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Commands, run length and photocell choice.
  input wire logic cmd_open,
  input wire logic cmd_close,
  input wire logic cmd_stop,
  input wire logic [7:0] lag,
  input wire logic hit,
  // Answers.
  output logic open_done,
  output logic close_done,
  output logic photo
);
  logic [1:0] run_q;
  logic [7:0] cnt_q;
  // A stopped run never reports done, as a drive cut in mid-travel would not.
  always_ff @(posedge aclk) begin
    open_done <= 1'b0;
    close_done <= 1'b0;
    photo <= hit && run_q != 2'h0 && cnt_q == 8'h02;
    if (!aresetn || cmd_stop) begin
      run_q <= 2'h0;
    end else if (cmd_open || cmd_close) begin
      run_q <= {cmd_close, cmd_open};
      cnt_q <= lag;
    end else if (run_q != 2'h0) begin
      cnt_q <= cnt_q - 8'h01;
      if (cnt_q == 8'h00) begin
        {close_done, open_done} <= run_q;
        run_q <= 2'h0;
      end
    end
  end
endmodule

// ===== verification/test_gate_button_menu_autoclose.sv
// Self-checking bench for the gate button menu and automatic closing.
`timescale 1ns/1ns
`include "gbm_params.svh"
module test_gate_button_menu_autoclose;
  localparam int ENTER = 20;
  localparam int IDLE = 50;
  localparam int SEC = 4;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [2:0] btn = 3'h0;
  logic safety_event = 1'b0;
  logic hit = 1'b0;
  logic [7:0] lag = 8'h06;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic photo, open_done, close_done, cmd_open, cmd_close, cmd_stop, bus_led, prog_active;
  logic [7:0] function_led_row;
  wire logic [2:0] cmds = {cmd_stop, cmd_close, cmd_open};
  int fail_count = 0;
  int check_count = 0;
  always #20 aclk = ~aclk;
  gbm_top #(.ENTER_CYC(ENTER), .IDLE_CYC(IDLE), .SEC_CYC(SEC), .BLINK_CYC(4)) i_gbm_top (
    .aclk(aclk), .aresetn(aresetn), .btn_open(btn[0]), .btn_halt(btn[1]),
    .btn_close(btn[2]), .photo(photo), .safety_event(safety_event),
    .open_done(open_done), .close_done(close_done), .cmd_open(cmd_open),
    .cmd_close(cmd_close), .cmd_stop(cmd_stop), .function_led_row(function_led_row),
    .bus_led(bus_led), .prog_active(prog_active), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  gbm_seq_model i_gbm_seq_model (.aclk(aclk), .aresetn(aresetn), .cmd_open(cmd_open),
    .cmd_close(cmd_close), .cmd_stop(cmd_stop), .lag(lag), .hit(hit),
    .open_done(open_done), .close_done(close_done), .photo(photo));
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    check_count++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask
  // A bus answer that never comes ends the run rather than hanging it.
  task automatic tmo(input int n);
    if (n >= 50) begin
      fail_count++;
      close_out();
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    tmo(n);
    chk({30'h0, s_axi_bresp}, 32'h0);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] re);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    tmo(n);
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, re});
  endtask
  task automatic push(input int b, input int len);
    @(posedge aclk);
    btn[b] <= 1'b1;
    repeat (len) @(posedge aclk);
    btn[b] <= 1'b0;
  endtask
  task automatic tap(input int b);
    push(b, 1);
    repeat (4) @(posedge aclk);
  endtask
  task automatic wait_cmd(input int k, input int lim, output int n);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (cmds[k] !== 1'b1 && n < lim);
  endtask
  task automatic lit(input int k, input int lo, input int hi);
    int c;
    c = 0;
    repeat (32) begin
      @(posedge aclk);
      c += (function_led_row[k] === 1'b1);
    end
    chk_rng(c, lo, hi);
  endtask
  // Press a button, then time the close command that follows the manoeuvre.
  task automatic run(input int b, input int k, input int lo, input int hi);
    int n;
    push(b, 1);
    wait_cmd(k, 10, n);
    chk_rng(n, 1, 4);
    wait_cmd(1, 100, n);
    chk_rng(n, lo, hi);
  endtask
  task automatic quiet();
    hit <= 1'b0;
    push(1, 1);
    wr(`GBM_OFF_FUNC, 32'h0);
    repeat (30) @(posedge aclk);
  endtask
  initial begin
    int n;
    logic b;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(function_led_row, 8'h00);
    rd(`GBM_OFF_FUNC, 32'h0, 2'h0);
    rd(`GBM_OFF_PAUSE, 32'h1e, 2'h0);
    rd(32'h10, 32'h0, 2'h2);
    run(0, 0, 100, 100);
    rd(`GBM_OFF_STATUS, 32'h0, 2'h0);
    lag <= 8'h28;
    push(0, 1);
    wait_cmd(0, 10, n);
    push(1, 1);
    wait_cmd(2, 10, n);
    chk_rng(n, 1, 6);
    lag <= 8'h06;
    repeat (60) @(posedge aclk);
    push(1, ENTER - 8);
    repeat (4) @(posedge aclk);
    chk(prog_active, 1'b0);
    push(1, ENTER + 5);
    repeat (4) @(posedge aclk);
    chk(prog_active, 1'b1);
    lit(0, 1, 8);
    tap(1);
    lit(0, 24, 31);
    tap(2);
    lit(7, 1, 8);
    tap(1);
    tap(0);
    tap(0);
    tap(1);
    rd(`GBM_OFF_CTRL, 32'h1, 2'h0);
    rd(`GBM_OFF_FUNC, 32'h83, 2'h0);
    n = 0;
    while (prog_active === 1'b1 && n < 100) begin
      @(posedge aclk);
      n++;
    end
    chk_rng(n, 20, 45);
    @(posedge aclk);
    chk(function_led_row, 8'h83);
    wr(`GBM_OFF_FUNC, 32'h01);
    wr(`GBM_OFF_PAUSE, 32'h0a);
    chk(function_led_row, 8'h01);
    run(0, 0, 42, 54);
    repeat (20) @(posedge aclk);
    wr(`GBM_OFF_FUNC, 32'h03);
    hit <= 1'b1;
    run(0, 0, 22, 34);
    quiet();
    wr(`GBM_OFF_FUNC, 32'h02);
    hit <= 1'b1;
    run(2, 1, 42, 54);
    quiet();
    hit <= 1'b1;
    run(2, 1, 100, 100);
    hit <= 1'b0;
    safety_event <= 1'b1;
    @(posedge aclk);
    safety_event <= 1'b0;
    n = 0;
    b = bus_led;
    repeat (20) begin
      @(posedge aclk);
      n += (bus_led !== b);
      b = bus_led;
    end
    chk_rng(n, 3, 8);
    close_out();
  end
endmodule
bind gbm_top gbm_top_checker #(.ENTER_CYC(ENTER_CYC), .IDLE_CYC(IDLE_CYC)) i_gbm_top_checker (
  .aclk(aclk), .aresetn(aresetn), .btn_open(btn_open), .btn_halt(btn_halt),
  .btn_close(btn_close), .cmd_open(cmd_open), .cmd_close(cmd_close), .cmd_stop(cmd_stop),
  .function_led_row(function_led_row), .prog_active(prog_active));
